// File: verilog/ooc_cfg.svh
// Constants for the output-one clock control block.
// Assumes inclusion by bare name from the block's package and modules.
//
// What this block does
// - Bit 7 set powers output driver down
// - Bit 6 picks fractional or integer division
// - Bit 5 picks first or second loop
// - Bit 4 inverts the selected output clock
// - Source 00 drives output from crystal
// - Source 01 buffers the reference clock input
// - Source 11 drives output from divider
`ifndef OOC_CFG_SVH
`define OOC_CFG_SVH

// Register address and reset value
`define OOC_CTRL_ADDR 8'h11
`define OOC_CTRL_RESET 8'h00

// Field positions
`define OOC_PDN_BIT 7
`define OOC_INT_BIT 6
`define OOC_REF_BIT 5
`define OOC_INV_BIT 4
`define OOC_SRC_HI 3
`define OOC_SRC_LO 2
`define OOC_RSVD_HI 1
`define OOC_RSVD_LO 0

// Source field encodings
`define OOC_SRC_CRYSTAL 2'h0
`define OOC_SRC_REFIN 2'h1
`define OOC_SRC_RSVD 2'h2
`define OOC_SRC_DIV 2'h3

// Park time around a source switch, in ns, and in cycles at 40 MHz
`define OOC_CLK_PERIOD_NS 25
`define OOC_SWITCH_PARK_NS 100
`define OOC_SWITCH_PARK_CYC \
  ((`OOC_SWITCH_PARK_NS + `OOC_CLK_PERIOD_NS - 1) / `OOC_CLK_PERIOD_NS)

`endif

// File: verilog/ooc_pkg.sv
// Types for the output-one clock control block.
// Assumes ooc_cfg.svh is on the include path.
`include "ooc_cfg.svh"

package ooc_pkg;

  // Control register image, bit 7 down to bit 0
  typedef struct packed {
    logic powerdown;
    logic integerMode;
    logic refSelect;
    logic invert;
    logic [1:0] sourceSelect;
    logic [1:0] reserved;
  } ooc_ctrl_t;

  // Raw clock levels entering the block
  typedef struct packed {
    logic firstLoop;
    logic secondLoop;
    logic crystal;
    logic refIn;
    logic divider;
  } ooc_srcs_t;

  typedef enum logic [2:0] {
    OOC_ST_OFF = 3'b001,
    OOC_ST_PARK = 3'b010,
    OOC_ST_RUN = 3'b100
  } ooc_state_t;

endpackage

// File: verilog/ooc_sync_bank.sv
// Bank of multi-stage synchronisers, one chain per bit.
// Assumes inputs are asynchronous to clk; output is the last stage.
`timescale 1ns/100ps

module ooc_sync_bank #(
  parameter int WIDTH = 5,
  parameter int STAGES = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Data
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  // Refuse chains too short to synchronise
  if (STAGES < 2 || WIDTH < 1) begin : g_bad_params
    $error("ooc_sync_bank: STAGES must be >= 2 and WIDTH >= 1");
  end

  genvar b;
  generate
    for (b = 0; b < WIDTH; b++) begin : g_bit
      logic [STAGES-1:0] chain;
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          chain <= '0;
        end else begin
          chain <= {chain[STAGES-2:0], asyncIn[b]};
        end
      end
      assign syncOut[b] = chain[STAGES-1];
    end
  endgenerate

endmodule

// File: verilog/ooc_top.sv
// Control logic for clock output one: register, source select, output.
// Assumes source clocks are asynchronous pins and far below 20 MHz,
// since they are sampled by the 40 MHz clock before reaching the output.
`timescale 1ns/100ps
`include "ooc_cfg.svh"

module ooc_top
  import ooc_pkg::*;
#(
  parameter int SYNC_STAGES = 2,
  parameter int PARK_CYCLES = `OOC_SWITCH_PARK_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Configuration port
  input wire logic cfgWrite,
  input wire logic cfgRead,
  input wire logic [7:0] cfgAddr,
  input wire logic [7:0] cfgWrData,
  output logic [7:0] cfgRdData,
  output logic cfgRdValid,
  // Source clocks
  input wire logic firstLoopSource,
  input wire logic secondLoopSource,
  input wire logic crystalOscillator,
  input wire logic refClockInput,
  input wire logic dividerClock,
  // Divider controls
  output logic out1DividerIntegerMode,
  output logic out1DividerRefSelect,
  output logic dividerRefClock,
  // Output one
  output logic clockOutputOne,
  output logic clockOutputOneOe_n,
  output logic out1Powerdown
);

  localparam logic [3:0] PARK_LAST = 4'(PARK_CYCLES - 1);

  // Park counter is four bits wide
  if (PARK_CYCLES < 1 || PARK_CYCLES > 16) begin : g_bad_park
    $error("ooc_top: PARK_CYCLES must lie in 1..16");
  end
  if (SYNC_STAGES < 2) begin : g_bad_sync
    $error("ooc_top: SYNC_STAGES must be at least 2");
  end

  // Field unpacking, used for writes and reset
  function automatic ooc_ctrl_t unpackCtrl(input logic [7:0] raw);
    ooc_ctrl_t c;
    c.powerdown = raw[`OOC_PDN_BIT];
    c.integerMode = raw[`OOC_INT_BIT];
    c.refSelect = raw[`OOC_REF_BIT];
    c.invert = raw[`OOC_INV_BIT];
    c.sourceSelect = raw[`OOC_SRC_HI:`OOC_SRC_LO];
    c.reserved = raw[`OOC_RSVD_HI:`OOC_RSVD_LO];
    return c;
  endfunction

  // Sampled level of the chosen output source
  function automatic logic pickSource(input logic [1:0] sel,
                                      input ooc_srcs_t s);
    logic lvl;
    lvl = 1'b0;
    unique case (sel)
      `OOC_SRC_CRYSTAL: lvl = s.crystal;
      `OOC_SRC_REFIN: lvl = s.refIn;
      `OOC_SRC_RSVD: lvl = 1'b0;
      `OOC_SRC_DIV: lvl = s.divider;
    endcase
    return lvl;
  endfunction

  ooc_ctrl_t ctrl;
  ooc_ctrl_t next_ctrl;
  ooc_srcs_t rawSrcs;
  ooc_srcs_t syncSrcs;
  ooc_state_t state;
  ooc_state_t next_state;
  logic [1:0] activeSource;
  logic activeInvert;
  logic [3:0] parkCount;
  logic [3:0] next_parkCount;

  // Configuration decode
  wire addrHit = (cfgAddr == `OOC_CTRL_ADDR);
  wire writeHit = cfgWrite && addrHit;
  wire [7:0] readMux = addrHit ? ctrl : 8'h00;

  // Synchronise every incoming clock level
  assign rawSrcs = '{firstLoop: firstLoopSource,
                     secondLoop: secondLoopSource,
                     crystal: crystalOscillator,
                     refIn: refClockInput,
                     divider: dividerClock};

  ooc_sync_bank #(
    .WIDTH($bits(ooc_srcs_t)),
    .STAGES(SYNC_STAGES)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .asyncIn(rawSrcs),
    .syncOut(syncSrcs)
  );

  // Control register; reserved bits are stored as written
  always_comb begin
    next_ctrl = ctrl;
    if (writeHit) begin
      next_ctrl = unpackCtrl(cfgWrData);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl <= unpackCtrl(`OOC_CTRL_RESET);
    end else begin
      ctrl <= next_ctrl;
    end
  end

  // Read port answers one cycle after the strobe
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfgRdData <= 8'h00;
      cfgRdValid <= 1'b0;
    end else begin
      cfgRdValid <= cfgRead;
      if (cfgRead) begin
        cfgRdData <= readMux;
      end
    end
  end

  // Divider mode, loop select and powerdown come straight from the register
  assign out1DividerIntegerMode = ctrl.integerMode;
  assign out1DividerRefSelect = ctrl.refSelect;
  assign out1Powerdown = ctrl.powerdown;

  // Divider reference follows the loop select
  wire nextDivRef = ctrl.refSelect ? syncSrcs.secondLoop
                                   : syncSrcs.firstLoop;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      dividerRefClock <= 1'b0;
    end else begin
      dividerRefClock <= nextDivRef;
    end
  end

  // Switch sequencing: park output low while source or polarity moves
  wire cfgMoved = (ctrl.sourceSelect != activeSource) ||
                  (ctrl.invert != activeInvert);
  wire parkDone = (parkCount == PARK_LAST);

  always_comb begin
    next_state = state;
    next_parkCount = parkCount;
    unique case (state)
      OOC_ST_OFF: begin
        next_parkCount = 4'h0;
        if (!ctrl.powerdown) begin
          next_state = OOC_ST_PARK;
        end
      end
      OOC_ST_PARK: begin
        next_parkCount = parkCount + 4'h1;
        if (ctrl.powerdown) begin
          next_state = OOC_ST_OFF;
          next_parkCount = 4'h0;
        end else if (cfgMoved) begin
          next_parkCount = 4'h0;
        end else if (parkDone) begin
          next_state = OOC_ST_RUN;
          next_parkCount = 4'h0;
        end
      end
      OOC_ST_RUN: begin
        next_parkCount = 4'h0;
        if (ctrl.powerdown) begin
          next_state = OOC_ST_OFF;
        end else if (cfgMoved) begin
          next_state = OOC_ST_PARK;
        end
      end
      default: begin
        next_state = OOC_ST_OFF;
        next_parkCount = 4'h0;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= OOC_ST_OFF;
      parkCount <= 4'h0;
    end else begin
      state <= next_state;
      parkCount <= next_parkCount;
    end
  end

  // Active selection follows the register while parked
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      activeSource <= `OOC_SRC_CRYSTAL;
      activeInvert <= 1'b0;
    end else if (state != OOC_ST_RUN) begin
      activeSource <= ctrl.sourceSelect;
      activeInvert <= ctrl.invert;
    end
  end

  // Output level: selected source, optionally inverted
  wire srcLevel = pickSource(activeSource, syncSrcs);
  wire runLevel = srcLevel ^ activeInvert;
  wire nextOut = (state == OOC_ST_RUN) ? runLevel : 1'b0;
  wire nextOe_n = ctrl.powerdown;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      clockOutputOne <= 1'b0;
      clockOutputOneOe_n <= 1'b1;
    end else begin
      clockOutputOne <= nextOut;
      clockOutputOneOe_n <= nextOe_n;
    end
  end

endmodule

// File: verification/ooc_host_model.sv
// Host model driving the configuration port of the control block.
// Assumes clk is the block clock; the bench calls wr and rd.
`timescale 1ns/100ps
module ooc_host_model (
  // Clock
  input wire logic clk,
  // Configuration port
  output logic cfgWrite = 1'b0,
  output logic cfgRead = 1'b0,
  output logic [7:0] cfgAddr = 8'h00,
  output logic [7:0] cfgWrData = 8'h00,
  input wire logic [7:0] cfgRdData,
  input wire logic cfgRdValid
);
  // Set by a test that wants the reserved source code sent
  logic rsvdOk = 1'b0;
  // No delay offset exists here, so integer mode is always legal
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    if (d[3:2] == 2'h2 && !rsvdOk) d[3:2] = 2'h3;
    @(posedge clk);
    cfgWrite <= 1'b1;
    cfgAddr <= a;
    cfgWrData <= {d[7:2], 2'b00};
    @(posedge clk);
    cfgWrite <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    cfgRead <= 1'b1;
    cfgAddr <= a;
    @(posedge clk);
    cfgRead <= 1'b0;
    #1;
    d = cfgRdValid ? cfgRdData : 8'hxx;
  endtask
endmodule

// File: verification/ooc_top_assertions.sv
// Checker for the output-one control block ports.
// Assumes it is bound into ooc_top.
`timescale 1ns/100ps
module ooc_top_assertions #(parameter int PARK_CYCLES = 4) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic cfgWrite,
  input wire logic [7:0] cfgAddr,
  input wire logic [7:0] cfgWrData,
  // Sources
  input wire logic crystalOscillator,
  input wire logic refClockInput,
  input wire logic dividerClock,
  // Outputs
  input wire logic out1DividerIntegerMode,
  input wire logic out1DividerRefSelect,
  input wire logic clockOutputOne,
  input wire logic clockOutputOneOe_n,
  input wire logic out1Powerdown
);
  logic [7:0] ctl;
  logic [5:0] quiet;
  wire wrHit = cfgWrite && cfgAddr == 8'h11;
  wire run = quiet > 6'(PARK_CYCLES + 8) && !ctl[7];
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Cycles since the last control write
  always_ff @(posedge clk) begin
    if (!rst_n || wrHit) begin
      quiet <= 6'h00;
    end else if (quiet != 6'h3f) begin
      quiet <= quiet + 6'h01;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctl <= 8'h00;
    end else if (wrHit) begin
      ctl <= cfgWrData;
    end
  end
  property p_route(logic [1:0] code, logic pin);
    $stable(pin) [*4] ##0 run && ctl[3:2] == code
      |-> clockOutputOne == (pin ^ ctl[4]);
  endproperty
  a_pdn_quiet: assert property (out1Powerdown [*4] |->
    clockOutputOneOe_n && !clockOutputOne) else $error("driver not off");
  a_pdn_drive: assert property (!out1Powerdown [*2] |=>
    !clockOutputOneOe_n) else $error("driver not on");
  a_int_field: assert property (wrHit |=>
    out1DividerIntegerMode == $past(cfgWrData[6])) else $error("int bit");
  a_ref_field: assert property (wrHit |=>
    out1DividerRefSelect == $past(cfgWrData[5])) else $error("ref bit");
  a_invert_rsvd: assert property (run && ctl[3:2] == 2'h2 |->
    clockOutputOne == ctl[4]) else $error("invert wrong");
  a_crystal_route: assert property (p_route(2'h0, crystalOscillator))
    else $error("crystal route");
  a_refin_route: assert property (p_route(2'h1, refClockInput))
    else $error("reference route");
  a_div_route: assert property (p_route(2'h3, dividerClock))
    else $error("divider route");
  c_pdn: cover property (out1Powerdown [*4]);
  c_inv: cover property (run && ctl[4]);
  c_div: cover property (run && ctl[3:2] == 2'h3);
endmodule
bind ooc_top ooc_top_assertions #(.PARK_CYCLES(PARK_CYCLES)) u_chk (
  .clk, .rst_n, .cfgWrite, .cfgAddr, .cfgWrData, .crystalOscillator,
  .refClockInput, .dividerClock, .out1DividerIntegerMode,
  .out1DividerRefSelect, .clockOutputOne, .clockOutputOneOe_n,
  .out1Powerdown);

// File: verification/output_one_clock_control_tb.sv
// Testbench for the output-one control block.
// Assumes the host model and the bound checker are compiled with it.
`timescale 1ns/100ps
module output_one_clock_control_tb
  import ooc_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  ooc_srcs_t src = 5'h00;
  logic cfgWrite, cfgRead, cfgRdValid, dividerRefClock, pin;
  logic out1DividerIntegerMode, out1DividerRefSelect, out1Powerdown;
  logic clockOutputOne, clockOutputOneOe_n;
  logic [7:0] cfgAddr, cfgWrData, cfgRdData, got, cfg;
  int errors = 0;
  int checks = 0;
  always #12.5 clk = ~clk;
  ooc_host_model u_host (.clk, .cfgWrite, .cfgRead, .cfgAddr, .cfgWrData,
    .cfgRdData, .cfgRdValid);
  ooc_top #(.PARK_CYCLES(1)) u_dut (
    .clk, .rst_n, .cfgWrite, .cfgRead, .cfgAddr, .cfgWrData, .cfgRdData,
    .cfgRdValid, .firstLoopSource(src.firstLoop),
    .secondLoopSource(src.secondLoop), .crystalOscillator(src.crystal),
    .refClockInput(src.refIn), .dividerClock(src.divider),
    .out1DividerIntegerMode, .out1DividerRefSelect, .dividerRefClock,
    .clockOutputOne, .clockOutputOneOe_n, .out1Powerdown);
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e) begin
      errors++;
      $display("mismatch at %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk);
    errors++;
    tally_and_finish();
  end
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    u_host.rd(8'h11, got);
    chk(got, 8'h00);
    $display("test reset done");
    u_host.rsvdOk = 1'b1;
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 8; i++) begin
        cfg = {1'b0, i[1], i[2], i[0], i[2:1], 2'b00};
        u_host.wr(8'h11, cfg);
        src <= p[0] ? 5'h15 : 5'h0a;
        repeat (14) @(posedge clk);
        #1;
        pin = i[2:1] == 0 ? src.crystal : i[2:1] == 1 ? src.refIn :
          i[2:1] == 3 ? src.divider : 1'b0;
        chk(out1DividerIntegerMode, i[1]);
        chk(out1DividerRefSelect, i[2]);
        chk(dividerRefClock, i[2] ? src.secondLoop : src.firstLoop);
        chk(clockOutputOneOe_n, 1'b0);
        chk(clockOutputOne, pin ^ i[0]);
        u_host.rd(8'h11, got);
        chk(got, cfg);
      end
    end
    $display("test routing done");
    u_host.wr(8'h11, 8'h8c);
    repeat (6) @(posedge clk);
    #1;
    chk(out1Powerdown, 1'b1);
    chk(clockOutputOneOe_n, 1'b1);
    chk(clockOutputOne, 1'b0);
    $display("test powerdown done");
    u_host.wr(8'h11, 8'h0c);
    u_host.wr(8'h12, 8'hff);
    u_host.rd(8'h11, got);
    chk(got, 8'h0c);
    u_host.rd(8'h12, got);
    chk(got, 8'h00);
    $display("test unmapped done");
    tally_and_finish();
  end
endmodule
